//--- rtl/csd_channel_scan_drive_cfg.sv
// Register bank for channel scan, deglitch filter, software reset and sensor drive.
`timescale 1ns/1ps
module csd_channel_scan_drive_cfg #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [15:0] regRdData,
  input wire logic [1:0] singleChannelSelect,
  input wire logic driveOverrideEnable,
  input wire logic amplitudeCorrectionOff,
  input wire logic convDone,
  input wire logic ampCorrDone,
  input wire logic [1:0] ampCorrChan,
  input wire logic [4:0] ampCorrDrive,
  output logic [1:0] activeChannel,
  output logic scanWrap,
  output logic [4:0] sensorDriveLevel,
  output logic sensorDriveOverride,
  output logic [2:0] deglitchCode,
  output logic [15:0] deglitchBandwidthKhz,
  output logic deviceResetReq
);

  // Only the two-channel and four-channel variants exist.
  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4) begin : g_bad_channels
    $error("csd_channel_scan_drive_cfg: NUM_CHANNELS must be 2 or 4");
  end

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [15:0] seqCtrlFf;
  logic [4:0] drvLevelFf [0:csd_pkg::NUM_DRV_REGS-1];
  logic [4:0] initDriveFf [0:csd_pkg::NUM_DRV_REGS-1];
  logic [csd_pkg::NUM_DRV_REGS-1:0] drvWrSel;
  logic swResetWrite;
  logic seqCtrlWrite;
  logic deviceResetReqFf;
  logic [15:0] rdMux;
  logic [15:0] regRdDataFf;
  logic [4:0] sensorDriveLevelFf;
  logic sensorDriveOverrideFf;
  logic [15:0] deglitchKhzFf;
  logic [15:0] nxt_deglitchKhzFf;
  logic ampUpdate;

  csd_seq_if seqBus ();

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  assign seqCtrlWrite = regWrEn && (regAddr == csd_pkg::OFS_SEQ_CTRL);
  assign swResetWrite = regWrEn && (regAddr == csd_pkg::OFS_SW_RESET)
    && regWrData[csd_pkg::SW_RESET_BIT];
  assign drvWrSel[0] = regWrEn && (regAddr == csd_pkg::OFS_DRV_CHAN0);
  assign drvWrSel[1] = regWrEn && (regAddr == csd_pkg::OFS_DRV_CHAN1);
  assign drvWrSel[2] = regWrEn && (regAddr == csd_pkg::OFS_DRV_CHAN2);

  // ------------------------------------------------------------
  // Scan control register
  // ------------------------------------------------------------
  // Reserved bits are stored as written so that a readback shows what the
  // host left there; the host is expected to keep the fixed pattern.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seqCtrlFf <= csd_pkg::SEQ_CTRL_RST;
    end else if (swResetWrite) begin
      seqCtrlFf <= csd_pkg::SEQ_CTRL_RST;
    end else if (seqCtrlWrite) begin
      seqCtrlFf <= regWrData;
    end
  end

  // ------------------------------------------------------------
  // Software reset request
  // ------------------------------------------------------------
  // The request is a single-cycle pulse; nothing is stored, so the bit
  // cannot be read back as one.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deviceResetReqFf <= 1'b0;
    end else begin
      deviceResetReqFf <= swResetWrite;
    end
  end

  // ------------------------------------------------------------
  // Per-channel drive registers
  // ------------------------------------------------------------
  assign ampUpdate = ampCorrDone && !amplitudeCorrectionOff;

  for (genvar ch = 0; ch < csd_pkg::NUM_DRV_REGS; ch++) begin : g_drv
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        drvLevelFf[ch] <= csd_pkg::DRV_RST;
      end else if (swResetWrite) begin
        drvLevelFf[ch] <= csd_pkg::DRV_RST;
      end else if (drvWrSel[ch]) begin
        drvLevelFf[ch] <= regWrData[csd_pkg::DRV_LVL_HI:csd_pkg::DRV_LVL_LO];
      end
    end

    // Calibration results keep flowing in even while software writes the
    // same register, because the field is read-only to software.
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        initDriveFf[ch] <= csd_pkg::DRV_RST;
      end else if (swResetWrite) begin
        initDriveFf[ch] <= csd_pkg::DRV_RST;
      end else if (ampUpdate && (ampCorrChan == 2'(ch))) begin
        initDriveFf[ch] <= ampCorrDrive;
      end
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    rdMux = 16'h0000;
    case (regAddr)
      csd_pkg::OFS_SEQ_CTRL: rdMux = seqCtrlFf;
      csd_pkg::OFS_SW_RESET: rdMux = 16'h0000;
      csd_pkg::OFS_DRV_CHAN0: begin
        rdMux[csd_pkg::DRV_LVL_HI:csd_pkg::DRV_LVL_LO] = drvLevelFf[0];
        rdMux[csd_pkg::INIT_DRV_HI:csd_pkg::INIT_DRV_LO] = initDriveFf[0];
      end
      csd_pkg::OFS_DRV_CHAN1: begin
        rdMux[csd_pkg::DRV_LVL_HI:csd_pkg::DRV_LVL_LO] = drvLevelFf[1];
        rdMux[csd_pkg::INIT_DRV_HI:csd_pkg::INIT_DRV_LO] = initDriveFf[1];
      end
      csd_pkg::OFS_DRV_CHAN2: begin
        rdMux[csd_pkg::DRV_LVL_HI:csd_pkg::DRV_LVL_LO] = drvLevelFf[2];
        rdMux[csd_pkg::INIT_DRV_HI:csd_pkg::INIT_DRV_LO] = initDriveFf[2];
      end
      default: rdMux = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdDataFf <= 16'h0000;
    end else if (regRdEn) begin
      regRdDataFf <= rdMux;
    end else begin
      regRdDataFf <= 16'h0000;
    end
  end

  // ------------------------------------------------------------
  // Channel sequencer
  // ------------------------------------------------------------
  assign seqBus.scanEnable = seqCtrlFf[csd_pkg::SCAN_EN_BIT];
  assign seqBus.rotationSequence = seqCtrlFf[csd_pkg::ROT_SEQ_HI:csd_pkg::ROT_SEQ_LO];
  assign seqBus.singleChannelSelect = singleChannelSelect;
  assign seqBus.convDone = convDone;
  assign seqBus.restart = deviceResetReqFf;

  csd_scan_seq #(
    .NUM_CHANNELS(NUM_CHANNELS)
  ) u_seq (
    .mclk(mclk),
    .rst_n(rst_n),
    .sq(seqBus.seq)
  );

  // ------------------------------------------------------------
  // Sensor drive selection
  // ------------------------------------------------------------
  // Channel 3 has no drive register in this bank, so it drives zero here.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sensorDriveOverrideFf <= 1'b0;
    end else begin
      sensorDriveOverrideFf <= driveOverrideEnable;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sensorDriveLevelFf <= csd_pkg::DRV_RST;
    end else begin
      if (driveOverrideEnable && (seqBus.activeChan < 2'(csd_pkg::NUM_DRV_REGS))) begin
        sensorDriveLevelFf <= drvLevelFf[seqBus.activeChan];
      end else begin
        sensorDriveLevelFf <= csd_pkg::DRV_RST;
      end
    end
  end

  // ------------------------------------------------------------
  // Deglitch bandwidth decode
  // ------------------------------------------------------------
  // Undefined codes fall back to the widest filter so no sensor is cut off.
  always_comb begin
    case (seqCtrlFf[csd_pkg::DEGLITCH_HI:csd_pkg::DEGLITCH_LO])
      csd_pkg::DGL_1MHZ: nxt_deglitchKhzFf = csd_pkg::BW_KHZ_1M;
      csd_pkg::DGL_3M3HZ: nxt_deglitchKhzFf = csd_pkg::BW_KHZ_3M3;
      csd_pkg::DGL_10MHZ: nxt_deglitchKhzFf = csd_pkg::BW_KHZ_10M;
      csd_pkg::DGL_33MHZ: nxt_deglitchKhzFf = csd_pkg::BW_KHZ_33M;
      default: nxt_deglitchKhzFf = csd_pkg::BW_KHZ_33M;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      deglitchKhzFf <= csd_pkg::BW_KHZ_33M;
    end else begin
      deglitchKhzFf <= nxt_deglitchKhzFf;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign regRdData = regRdDataFf;
  assign activeChannel = seqBus.activeChan;
  assign scanWrap = seqBus.listWrap;
  assign sensorDriveLevel = sensorDriveLevelFf;
  assign sensorDriveOverride = sensorDriveOverrideFf;
  assign deglitchCode = seqCtrlFf[csd_pkg::DEGLITCH_HI:csd_pkg::DEGLITCH_LO];
  assign deglitchBandwidthKhz = deglitchKhzFf;
  assign deviceResetReq = deviceResetReqFf;

endmodule : csd_channel_scan_drive_cfg

//--- rtl/csd_pkg.sv
// Constants for the channel scan and sensor drive configuration block.
package csd_pkg;

  // ----------------------------------------------------------------
  // Register port geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int DRV_W = 5;
  localparam int CHAN_W = 2;
  localparam int NUM_DRV_REGS = 3;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_SEQ_CTRL = 8'h1B;
  localparam logic [7:0] OFS_SW_RESET = 8'h1C;
  localparam logic [7:0] OFS_DRV_CHAN0 = 8'h1E;
  localparam logic [7:0] OFS_DRV_CHAN1 = 8'h1F;
  localparam logic [7:0] OFS_DRV_CHAN2 = 8'h20;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SCAN_EN_BIT = 15;
  localparam int ROT_SEQ_HI = 14;
  localparam int ROT_SEQ_LO = 13;
  localparam int DEGLITCH_HI = 2;
  localparam int DEGLITCH_LO = 0;
  localparam int SW_RESET_BIT = 15;
  localparam int DRV_LVL_HI = 15;
  localparam int DRV_LVL_LO = 11;
  localparam int INIT_DRV_HI = 10;
  localparam int INIT_DRV_LO = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SEQ_CTRL_RST = 16'h020F;
  localparam logic [4:0] DRV_RST = 5'h00;

  // ----------------------------------------------------------------
  // Rotation codes and deglitch bandwidth codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ROT_CH01 = 2'h0;
  localparam logic [1:0] ROT_CH012 = 2'h1;
  localparam logic [1:0] ROT_CH0123 = 2'h2;
  localparam logic [1:0] ROT_CH01B = 2'h3;
  localparam logic [2:0] DGL_1MHZ = 3'h1;
  localparam logic [2:0] DGL_3M3HZ = 3'h4;
  localparam logic [2:0] DGL_10MHZ = 3'h5;
  localparam logic [2:0] DGL_33MHZ = 3'h7;
  localparam logic [15:0] BW_KHZ_1M = 16'h03E8;
  localparam logic [15:0] BW_KHZ_3M3 = 16'h0CE4;
  localparam logic [15:0] BW_KHZ_10M = 16'h2710;
  localparam logic [15:0] BW_KHZ_33M = 16'h80E8;

endpackage : csd_pkg

//--- rtl/csd_scan_seq.sv
// Channel sequencer: single-channel or round-robin scan over a channel list.
`timescale 1ns/1ps
module csd_scan_seq #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  csd_seq_if.seq sq
);

  // Only the two-channel and four-channel variants exist.
  if (NUM_CHANNELS != 2 && NUM_CHANNELS != 4) begin : g_bad_channels
    $error("csd_scan_seq: NUM_CHANNELS must be 2 or 4");
  end

  logic [1:0] lastPos;
  logic [1:0] posFf;
  logic [1:0] nxt_posFf;
  logic [1:0] activeChanFf;
  logic listWrapFf;

  // ------------------------------------------------------------
  // List length decode
  // ------------------------------------------------------------
  // A two-channel part only ever walks channels 0 and 1.
  always_comb begin
    case (sq.rotationSequence)
      csd_pkg::ROT_CH01: lastPos = 2'h1;
      csd_pkg::ROT_CH012: lastPos = (NUM_CHANNELS == 4) ? 2'h2 : 2'h1;
      csd_pkg::ROT_CH0123: lastPos = (NUM_CHANNELS == 4) ? 2'h3 : 2'h1;
      csd_pkg::ROT_CH01B: lastPos = 2'h1;
      default: lastPos = 2'h1;
    endcase
  end

  // ------------------------------------------------------------
  // Position in the list
  // ------------------------------------------------------------
  always_comb begin
    nxt_posFf = posFf;
    if (!sq.scanEnable) begin
      nxt_posFf = 2'h0;
    end else if (sq.convDone) begin
      nxt_posFf = (posFf >= lastPos) ? 2'h0 : posFf + 2'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      posFf <= 2'h0;
    end else if (sq.restart) begin
      posFf <= 2'h0;
    end else begin
      posFf <= nxt_posFf;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      listWrapFf <= 1'b0;
    end else begin
      listWrapFf <= sq.scanEnable && sq.convDone && !sq.restart && (posFf >= lastPos);
    end
  end

  // ------------------------------------------------------------
  // Channel handed to the conversion engine
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      activeChanFf <= 2'h0;
    end else if (sq.restart) begin
      activeChanFf <= 2'h0;
    end else if (sq.scanEnable) begin
      activeChanFf <= nxt_posFf;
    end else begin
      activeChanFf <= sq.singleChannelSelect;
    end
  end

  assign sq.activeChan = activeChanFf;
  assign sq.listWrap = listWrapFf;

endmodule : csd_scan_seq

//--- rtl/csd_seq_if.sv
// Interface between the register bank and the channel sequencer.
`timescale 1ns/1ps
interface csd_seq_if;
  logic scanEnable;
  logic [1:0] rotationSequence;
  logic [1:0] singleChannelSelect;
  logic convDone;
  logic restart;
  logic [1:0] activeChan;
  logic listWrap;

  modport cfg (
    output scanEnable,
    output rotationSequence,
    output singleChannelSelect,
    output convDone,
    output restart,
    input activeChan,
    input listWrap
  );

  modport seq (
    input scanEnable,
    input rotationSequence,
    input singleChannelSelect,
    input convDone,
    input restart,
    output activeChan,
    output listWrap
  );
endinterface : csd_seq_if

//--- sim/csd_cfg_sva.sv
// Assertion checker for the channel scan and drive configuration bank.
`timescale 1ns/1ps
module csd_cfg_sva #(
  parameter int NUM_CHANNELS = 4
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regRdData,
  input wire logic driveOverrideEnable,
  input wire logic convDone,
  input wire logic [1:0] activeChannel,
  input wire logic scanWrap,
  input wire logic [4:0] sensorDriveLevel,
  input wire logic sensorDriveOverride,
  input wire logic [2:0] deglitchCode,
  input wire logic [15:0] deglitchBandwidthKhz,
  input wire logic deviceResetReq
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [15:0] expBw;
  logic swRstWr;
  assign swRstWr = regWrEn && (regAddr == csd_pkg::OFS_SW_RESET) && regWrData[15];
  always_comb begin
    case (deglitchCode)
      csd_pkg::DGL_1MHZ: expBw = 16'h03E8;
      csd_pkg::DGL_3M3HZ: expBw = 16'h0CE4;
      csd_pkg::DGL_10MHZ: expBw = 16'h2710;
      default: expBw = 16'h80E8;
    endcase
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_reset_reads_zero: assert property ($past(regRdEn) && $past(regAddr) == csd_pkg::OFS_SW_RESET
    |-> regRdData == 16'h0000) else $error("reset register read back nonzero");
  chk_swrst_pulse_once: assert property (swRstWr |=> deviceResetReq ##1 !deviceResetReq)
    else $error("device reset request not a single pulse");
  chk_swrst_has_cause: assert property (deviceResetReq |-> $past(swRstWr))
    else $error("device reset request without reset write");
  chk_override_copy: assert property ($past(rst_n) |-> sensorDriveOverride == $past(driveOverrideEnable))
    else $error("override output not a delayed copy");
  chk_override_off_zero: assert property ($past(rst_n) && !$past(driveOverrideEnable)
    |-> sensorDriveLevel == 5'h00) else $error("drive level applied without override");
  chk_chan3_drive_zero: assert property ($past(rst_n) && $past(activeChannel) == 2'h3
    |-> sensorDriveLevel == 5'h00) else $error("channel three drive level nonzero");
  chk_bw_decode: assert property ($stable(deglitchCode) |-> deglitchBandwidthKhz == $past(expBw))
    else $error("deglitch bandwidth decode wrong");
  chk_wrap_list_end: assert property (scanWrap |-> $past(convDone) && activeChannel == 2'h0)
    else $error("scan wrap without restart at channel zero");
  chk_drv_low_zero: assert property ($past(regRdEn) && $past(regAddr) >= csd_pkg::OFS_DRV_CHAN0
    && $past(regAddr) <= csd_pkg::OFS_DRV_CHAN2 |-> regRdData[5:0] == 6'h00)
    else $error("drive register low bits nonzero");
endmodule : csd_cfg_sva

bind csd_channel_scan_drive_cfg csd_cfg_sva #(.NUM_CHANNELS(NUM_CHANNELS)) csd_cfg_sva_inst (
  .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .driveOverrideEnable(driveOverrideEnable),
  .convDone(convDone), .activeChannel(activeChannel), .scanWrap(scanWrap),
  .sensorDriveLevel(sensorDriveLevel), .sensorDriveOverride(sensorDriveOverride),
  .deglitchCode(deglitchCode), .deglitchBandwidthKhz(deglitchBandwidthKhz),
  .deviceResetReq(deviceResetReq));

//--- sim/csd_host_model.sv
// Host master model for the register port.
`timescale 1ns/1ps
module csd_host_model (
  input wire logic mclk,
  output logic [7:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWrEn,
  output logic regRdEn,
  input wire logic [15:0] regRdData
);
  initial begin
    regAddr = 8'h00;
    regWrData = 16'h0000;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge mclk);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge mclk);
    regRdEn <= 1'b0;
    @(posedge mclk);
    d = regRdData;
  endtask : rd
endmodule : csd_host_model

//--- sim/tb.sv
// Self-checking bench for the channel scan and drive configuration bank.
`timescale 1ns/1ps
module tb;
  logic mclk, rst_n, regWrEn, regRdEn, driveOverrideEnable, amplitudeCorrectionOff;
  logic convDone, ampCorrDone, scanWrap, sensorDriveOverride, deviceResetReq;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, deglitchBandwidthKhz, rdv, d;
  logic [1:0] singleChannelSelect, ampCorrChan, activeChannel;
  logic [4:0] ampCorrDrive, sensorDriveLevel;
  logic [2:0] deglitchCode;
  logic [31:0] r;
  int errCount, numChecks, cyc, seed, seqM;
  int drvM[3];
  int initM[3];
  int lenT[4] = '{2, 3, 4, 2};
  int bwT[4] = '{1000, 3300, 10000, 33000};
  logic [2:0] dglT[4] = '{3'h1, 3'h4, 3'h5, 3'h7};
  logic [7:0] addrT[6] = '{8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F, 8'h20};

  csd_channel_scan_drive_cfg #(.NUM_CHANNELS(4)) csd_channel_scan_drive_cfg_inst (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .singleChannelSelect(singleChannelSelect),
    .driveOverrideEnable(driveOverrideEnable), .amplitudeCorrectionOff(amplitudeCorrectionOff),
    .convDone(convDone), .ampCorrDone(ampCorrDone), .ampCorrChan(ampCorrChan),
    .ampCorrDrive(ampCorrDrive), .activeChannel(activeChannel), .scanWrap(scanWrap),
    .sensorDriveLevel(sensorDriveLevel), .sensorDriveOverride(sensorDriveOverride),
    .deglitchCode(deglitchCode), .deglitchBandwidthKhz(deglitchBandwidthKhz),
    .deviceResetReq(deviceResetReq));
  csd_host_model csd_host_model_inst (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData));

  // ----------------------------------------------------------------
  // Clock, timeout and checking tasks
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errCount++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp
  task automatic cmp_rd(input logic [7:0] a);
    logic [15:0] e;
    int i;
    e = 16'h0000;
    i = int'(a) - 16'h1E;
    if (a == csd_pkg::OFS_SEQ_CTRL) e = 16'(seqM);
    if (i >= 0 && i < 3) e = 16'((drvM[i] << 11) | (initM[i] << 6));
    csd_host_model_inst.rd(a, rdv);
    cmp(rdv, e, "register read");
  endtask : cmp_rd
  task automatic mreset();
    seqM = 16'h020F;
    foreach (drvM[i]) begin
      drvM[i] = 0;
      initM[i] = 0;
    end
  endtask : mreset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'hAE5F;
    errCount = 0;
    numChecks = 0;
    rst_n = 1'b0;
    {singleChannelSelect, driveOverrideEnable, amplitudeCorrectionOff} = 4'h0;
    {convDone, ampCorrDone, ampCorrChan, ampCorrDrive} = 9'h000;
    mreset();
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (addrT[i]) cmp_rd(addrT[i]);
    $display("test reset values done");
    for (int c = 0; c < 3; c++) begin
      d = 16'($random(seed));
      drvM[c] = d[15:11];
      csd_host_model_inst.wr(8'(8'h1E + c), d);
      csd_host_model_inst.wr(8'h1D, ~d);
      cmp_rd(8'(8'h1E + c));
    end
    $display("test drive registers done");
    repeat (12) begin
      r = $random(seed);
      @(posedge mclk);
      {ampCorrChan, ampCorrDrive, amplitudeCorrectionOff} <= r[7:0];
      ampCorrDone <= 1'b1;
      @(posedge mclk);
      ampCorrDone <= 1'b0;
      if (!r[0] && r[7:6] != 2'h3) initM[r[7:6]] = r[5:1];
      cmp_rd(8'(8'h1E + r[7:6] % 3));
    end
    $display("test calibration done");
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      @(posedge mclk);
      singleChannelSelect <= 2'(s);
      driveOverrideEnable <= r[0];
      repeat (3) @(posedge mclk);
      #1 cmp(16'(activeChannel), 16'(s), "single channel");
      cmp(16'(sensorDriveLevel), (r[0] && s < 3) ? 16'(drvM[s % 3]) : 16'h0000, "drive");
      cmp(16'(sensorDriveOverride), 16'(r[0]), "override");
    end
    $display("test single channel done");
    for (int k = 0; k < 4; k++) begin
      seqM = 16'h0208 | dglT[k];
      csd_host_model_inst.wr(csd_pkg::OFS_SEQ_CTRL, 16'(seqM));
      repeat (3) @(posedge mclk);
      seqM = seqM | 16'h8000 | (k << 13);
      csd_host_model_inst.wr(csd_pkg::OFS_SEQ_CTRL, 16'(seqM));
      repeat (3) @(posedge mclk);
      #1 cmp(16'(activeChannel), 16'h0000, "scan start");
      cmp(deglitchBandwidthKhz, 16'(bwT[k]), "bandwidth");
      cmp(16'(deglitchCode), 16'(dglT[k]), "deglitch code");
      cmp_rd(csd_pkg::OFS_SEQ_CTRL);
      for (int n = 1; n <= lenT[k]; n++) begin
        @(posedge mclk);
        convDone <= 1'b1;
        @(posedge mclk);
        convDone <= 1'b0;
        #1 cmp(16'(activeChannel), 16'(n % lenT[k]), "scan step");
        cmp(16'(scanWrap), 16'(n == lenT[k]), "scan wrap");
      end
    end
    $display("test scan lists done");
    csd_host_model_inst.wr(csd_pkg::OFS_SW_RESET, 16'h8000 | 16'($random(seed)));
    #1 cmp(16'(deviceResetReq), 16'h0001, "reset request");
    mreset();
    foreach (addrT[i]) cmp_rd(addrT[i]);
    $display("test software reset done");
    end_sim();
  end
endmodule : tb
